//--- include/entry_regs.svh
`ifndef ENTRY_REGS_SVH
`define ENTRY_REGS_SVH
`define FC_SUPER_DATA 3'h5
`define FC_SUPER_PROG 3'h6
`define FC_CPU_SPACE 3'h7
`define CPU_TYPE_INTERRUPT_ACK_CYCLE 4'hF
`define AUTOVEC_BASE 8'h18
`define SPURIOUS_VEC 8'h18
`define RESET_VEC 8'h00
`define SR_T_BIT 15
`define SR_S_BIT 13
`define SR_MASK_HI 10
`define SR_MASK_LO 8
`define PREP_CLKS 5'h06
`define JUSTIFY_CLKS 5'h04
`define VEC_WORDS_NORMAL 2'h1
`define VEC_WORDS_RESET 2'h3
`define SLOW_DIV_DEFAULT 5
`endif

//--- include/entry_pkg.sv
package entry_pkg;
   typedef enum logic [9:0] {
      S_IDLE = 10'h001,
      S_PREP = 10'h002,
      S_PUSH_PCL = 10'h004,
      S_INTERRUPT_ACK_CYCLE = 10'h008,
      S_JUST = 10'h010,
      S_PUSH_SR = 10'h020,
      S_PUSH_PCH = 10'h040,
      S_VEC = 10'h080,
      S_FETCH = 10'h100,
      S_FIN = 10'h200
   } entry_state_e;

   typedef struct packed {
      entry_state_e st;
      logic [4:0] cnt;
      logic [2:0] ph;
      logic [2:0] level;
      logic rst_entry;
      logic [15:0] sr_copy;
      logic [15:0] sr;
      logic [31:0] pc;
      logic [31:0] ssp;
      logic [7:0] vnum;
      logic [1:0] widx;
      logic [63:0] vw;
      logic [15:0] first;
      logic [23:1] addr;
      logic [2:0] fc;
      logic as_n;
      logic ds_n;
      logic rw;
      logic doe;
      logic [15:0] dout;
      logic busy;
      logic done;
   } entry_s;

   typedef enum logic [1:0] {
      R_IDLE = 2'h1,
      R_HOLD = 2'h2
   } resp_state_e;

   typedef struct packed {
      resp_state_e st;
      logic ack_n;
      logic av_n;
      logic fault_n;
      logic doe;
      logic [15:0] dout;
      logic seen;
      logic [2:0] seen_level;
      logic [4:0] div;
      logic slow;
   } resp_s;
endpackage

//--- include/entry_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface entry_bus_if;
   logic [23:1] address;
   logic function_code_bit2;
   logic function_code_bit1;
   logic function_code_bit0;
   logic address_strobe_n;
   logic upper_byte_strobe_n;
   logic lower_byte_strobe_n;
   logic read_write;
   logic [15:0] cpu_data;
   logic cpu_data_oe;
   logic [15:0] periph_data;
   logic periph_data_oe;
   logic [15:0] data_bus;
   logic transfer_ack_n;
   logic autovector_req_n;
   logic bus_fault_n;
   logic slow_sync_clock;

   // Undriven bus floats high through pull-ups
   assign data_bus = cpu_data_oe ? cpu_data :
                     (periph_data_oe ? periph_data : 16'hFFFF);

   modport cpu (
      output address, function_code_bit2, function_code_bit1,
      output function_code_bit0, address_strobe_n, upper_byte_strobe_n,
      output lower_byte_strobe_n, read_write, cpu_data, cpu_data_oe,
      input data_bus, transfer_ack_n, autovector_req_n, bus_fault_n,
      input slow_sync_clock
   );
   modport periph (
      input address, function_code_bit2, function_code_bit1,
      input function_code_bit0, address_strobe_n, upper_byte_strobe_n,
      input lower_byte_strobe_n, read_write, data_bus,
      output periph_data, periph_data_oe, transfer_ack_n,
      output autovector_req_n, bus_fault_n, slow_sync_clock
   );
endinterface
`default_nettype wire

//--- rtl/interrupt_responder.sv
`timescale 1ns/1ps
`default_nettype none
`include "entry_regs.svh"
module interrupt_responder #(
   parameter int SLOW_DIV = `SLOW_DIV_DEFAULT
) (
   input wire logic CLK,
   input wire logic SYS_RST,
   entry_bus_if.periph BUS,
   input wire logic AUTOVECTOR_MODE,
   input wire logic FAULT_MODE,
   input wire logic [7:0] VECTOR_NUMBER,
   input wire logic MEM_WE,
   input wire logic [3:0] MEM_ADDR,
   input wire logic [15:0] MEM_WDATA,
   output logic INTERRUPT_ACK_CYCLE_SEEN,
   output logic [2:0] INTERRUPT_ACK_CYCLE_LEVEL
);
   entry_pkg::resp_s q, n;
   logic [15:0] mem [0:15];
   logic interrupt_ack_cycle;
   logic cyc;

   assign cyc = !BUS.address_strobe_n;
   assign interrupt_ack_cycle = BUS.function_code_bit2 && BUS.function_code_bit1 &&
                 BUS.function_code_bit0 &&
                 BUS.address[19:16] == `CPU_TYPE_INTERRUPT_ACK_CYCLE;

   always_comb begin
      n = q;
      n.seen = 1'b0;
      if (q.div == 5'(SLOW_DIV - 1)) begin
         n.div = 5'h00;
         n.slow = !q.slow;
      end else begin
         n.div = q.div + 5'h01;
      end
      unique case (q.st)
         entry_pkg::R_IDLE: begin
            if (cyc) begin
               n.st = entry_pkg::R_HOLD;
               if (interrupt_ack_cycle) begin
                  n.seen = 1'b1;
                  n.seen_level = BUS.address[3:1];
                  // One answer only, never both acknowledges
                  if (FAULT_MODE) begin
                     n.fault_n = 1'b0;
                  end else if (AUTOVECTOR_MODE) begin
                     n.av_n = 1'b0;
                  end else begin
                     n.dout = {8'hFF, VECTOR_NUMBER};
                     n.doe = 1'b1;
                     n.ack_n = 1'b0;
                  end
               end else begin
                  n.ack_n = 1'b0;
                  n.doe = BUS.read_write;
                  n.dout = mem[BUS.address[4:1]];
               end
            end
         end
         entry_pkg::R_HOLD: begin
            if (!cyc) begin
               n.st = entry_pkg::R_IDLE;
               n.ack_n = 1'b1;
               n.av_n = 1'b1;
               n.fault_n = 1'b1;
               n.doe = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         q <= '{st: entry_pkg::R_IDLE, ack_n: 1'b1, av_n: 1'b1,
                fault_n: 1'b1, doe: 1'b0, dout: 16'h0000, seen: 1'b0,
                seen_level: 3'h0, div: 5'h00, slow: 1'b0};
      end else begin
         q <= n;
      end
   end

   // Loader port wins over a bus write in the same cycle
   always_ff @(posedge CLK) begin
      if (MEM_WE) begin
         mem[MEM_ADDR] <= MEM_WDATA;
      end else if (q.st == entry_pkg::R_IDLE && cyc && !interrupt_ack_cycle &&
                   !BUS.read_write) begin
         mem[BUS.address[4:1]] <= BUS.data_bus;
      end
   end

   assign BUS.transfer_ack_n = q.ack_n;
   assign BUS.autovector_req_n = q.av_n;
   assign BUS.bus_fault_n = q.fault_n;
   assign BUS.periph_data = q.dout;
   assign BUS.periph_data_oe = q.doe;
   assign BUS.slow_sync_clock = q.slow;
   assign INTERRUPT_ACK_CYCLE_SEEN = q.seen;
   assign INTERRUPT_ACK_CYCLE_LEVEL = q.seen_level;
endmodule
`default_nettype wire

//--- rtl/interrupt_entry_unit.sv
// Contract
// - All function codes high mark CPU space
// - Only type code all ones: interrupt acknowledge
// - Level on A3-A1, other address lines high
// - Peripheral drives vector, asserts transfer acknowledge
// - Both strobes asserted, upper data byte ignored
// - Copy status, set S, clear T, six clocks
// - Push low PC word before acknowledge
// - Acknowledge four clocks; autovector ten to eighteen (here five to fourteen clocks with SLOW_DIV 5)
// - Four idle clocks justify vector into address
// - Push status, high PC, read vector, fetch
// - Autovector request replaces acknowledge in state four
// - Autovector number is 18 hex plus level
// - Autovectors for levels one to seven
// - Wait for slow clock low, minimal waits
// - Sync delay whole clocks, three to two
// - Autovector cycle ends, strobes negated, slow low
// - Autovector request withdrawn within one clock
// - Never acknowledge and autovector together
// - Save status, get vector, save, load context
// - Two-word data vectors; reset four-word program
// - Vector address is number shifted left two
// - Vector number on low data byte
// - Bus fault in acknowledge takes spurious vector
`timescale 1ns/1ps
`default_nettype none
`include "entry_regs.svh"
module interrupt_entry_unit (
   input wire logic CLK,
   input wire logic SYS_RST,
   entry_bus_if.cpu BUS,
   input wire logic ENTRY_REQ,
   input wire logic RESET_ENTRY,
   input wire logic [2:0] ENTRY_LEVEL,
   input wire logic [15:0] STATUS_IN,
   input wire logic [31:0] PC_IN,
   input wire logic [31:0] SSP_IN,
   output logic BUSY,
   output logic DONE,
   output logic [15:0] STATUS_OUT,
   output logic [15:0] SAVED_STATUS,
   output logic [31:0] HANDLER_PC,
   output logic [31:0] NEW_SSP,
   output logic [7:0] VECTOR_NUM,
   output logic [15:0] FIRST_WORD
);
   entry_pkg::entry_s q, n;

   function automatic logic [31:0] vector_address(input logic [7:0] v);
      vector_address = {22'h000000, v, 2'b00};
   endfunction

   function automatic logic [23:1] interrupt_ack_cycle_address(input logic [2:0] lvl);
      interrupt_ack_cycle_address = {4'hF, `CPU_TYPE_INTERRUPT_ACK_CYCLE, 12'hFFF, lvl};
   endfunction

   logic bus_st;
   logic bus_wr;
   logic bus_end;
   logic [23:1] bus_a;
   logic [2:0] bus_fc;
   logic [15:0] bus_d;
   logic [31:0] ssp_m2, ssp_m4, ssp_m6, vaddr;
   entry_pkg::entry_state_e nxt;

   assign ssp_m2 = q.ssp - 32'h00000002;
   assign ssp_m4 = q.ssp - 32'h00000004;
   assign ssp_m6 = q.ssp - 32'h00000006;
   assign vaddr = vector_address(q.vnum) + {29'h0, q.widx, 1'b0};

   always_comb begin
      bus_st = 1'b1;
      bus_wr = 1'b0;
      bus_a = q.pc[23:1];
      bus_fc = `FC_SUPER_DATA;
      bus_d = 16'h0000;
      nxt = entry_pkg::S_FIN;
      unique case (q.st)
         entry_pkg::S_PUSH_PCL: begin
            bus_wr = 1'b1;
            bus_a = ssp_m2[23:1];
            bus_d = q.pc[15:0];
            nxt = entry_pkg::S_INTERRUPT_ACK_CYCLE;
         end
         entry_pkg::S_INTERRUPT_ACK_CYCLE: begin
            bus_a = interrupt_ack_cycle_address(q.level);
            bus_fc = `FC_CPU_SPACE;
            nxt = entry_pkg::S_JUST;
         end
         entry_pkg::S_PUSH_SR: begin
            bus_wr = 1'b1;
            bus_a = ssp_m6[23:1];
            bus_d = q.sr_copy;
            nxt = entry_pkg::S_PUSH_PCH;
         end
         entry_pkg::S_PUSH_PCH: begin
            bus_wr = 1'b1;
            bus_a = ssp_m4[23:1];
            bus_d = q.pc[31:16];
            nxt = entry_pkg::S_VEC;
         end
         entry_pkg::S_VEC: begin
            bus_a = vaddr[23:1];
            // Reset vector lives in program space
            bus_fc = q.rst_entry ? `FC_SUPER_PROG : `FC_SUPER_DATA;
            nxt = (q.widx == (q.rst_entry ? `VEC_WORDS_RESET :
                   `VEC_WORDS_NORMAL)) ? entry_pkg::S_FETCH :
                   entry_pkg::S_VEC;
         end
         entry_pkg::S_FETCH: begin
            bus_fc = `FC_SUPER_PROG;
            nxt = entry_pkg::S_FIN;
         end
         default: begin
            bus_st = 1'b0;
         end
      endcase
   end

   always_comb begin
      n = q;
      n.done = 1'b0;
      bus_end = 1'b0;
      unique case (q.st)
         entry_pkg::S_IDLE: begin
            if (ENTRY_REQ) begin
               n.busy = 1'b1;
               n.level = ENTRY_LEVEL;
               n.rst_entry = RESET_ENTRY;
               n.sr_copy = STATUS_IN;
               n.sr = STATUS_IN;
               n.pc = PC_IN;
               n.ssp = SSP_IN;
               n.cnt = 5'h01;
               n.ph = 3'h0;
               n.widx = 2'h0;
               n.vnum = `RESET_VEC;
               n.st = RESET_ENTRY ? entry_pkg::S_VEC : entry_pkg::S_PREP;
            end
         end
         entry_pkg::S_PREP: begin
            // Strobes already high from the last cycle end
            n.cnt = q.cnt + 5'h01;
            if (q.cnt == `PREP_CLKS) begin
               n.sr[`SR_S_BIT] = 1'b1;
               n.sr[`SR_T_BIT] = 1'b0;
               n.sr[`SR_MASK_HI:`SR_MASK_LO] = q.level;
               n.st = entry_pkg::S_PUSH_PCL;
            end
         end
         entry_pkg::S_JUST: begin
            n.cnt = q.cnt + 5'h01;
            if (q.cnt == `JUSTIFY_CLKS) begin
               n.st = entry_pkg::S_PUSH_SR;
            end
         end
         entry_pkg::S_FIN: begin
            n.done = 1'b1;
            n.busy = 1'b0;
            n.st = entry_pkg::S_IDLE;
         end
         default: begin
         end
      endcase
      if (bus_st) begin
         unique case (q.ph)
            3'h0: begin
               n.addr = bus_a;
               n.fc = bus_fc;
               n.rw = !bus_wr;
               n.dout = bus_d;
               n.doe = bus_wr;
               n.as_n = 1'b0;
               n.ph = 3'h1;
            end
            3'h1: begin
               n.ds_n = 1'b0;
               n.ph = 3'h2;
            end
            3'h2: begin
               if (!BUS.transfer_ack_n) begin
                  n.ph = 3'h3;
                  if (q.st == entry_pkg::S_INTERRUPT_ACK_CYCLE) begin
                     n.vnum = BUS.data_bus[7:0];
                  end else if (q.st == entry_pkg::S_VEC) begin
                     n.vw = {q.vw[47:0], BUS.data_bus};
                  end else if (q.st == entry_pkg::S_FETCH) begin
                     n.first = BUS.data_bus;
                  end
               end else if (q.st == entry_pkg::S_INTERRUPT_ACK_CYCLE &&
                            !BUS.autovector_req_n) begin
                  n.ph = 3'h4;
               end else if (q.st == entry_pkg::S_INTERRUPT_ACK_CYCLE &&
                            !BUS.bus_fault_n) begin
                  n.vnum = `SPURIOUS_VEC;
                  n.ph = 3'h3;
               end
            end
            3'h3: begin
               bus_end = 1'b1;
            end
            3'h4: begin
               // Waits only as long as the slow clock needs
               if (BUS.slow_sync_clock) begin
                  n.ph = 3'h5;
               end
            end
            default: begin
               if (!BUS.slow_sync_clock) begin
                  // No bus data used; level 0 is not filtered out and gives vector 18h
                  n.vnum = `AUTOVEC_BASE + {5'h00, q.level};
                  bus_end = 1'b1;
               end
            end
         endcase
      end
      if (bus_end) begin
         n.as_n = 1'b1;
         n.ds_n = 1'b1;
         n.doe = 1'b0;
         n.rw = 1'b1;
         n.ph = 3'h0;
         // Next bus cycle's first clock is not part of the idle count
         n.cnt = 5'h01;
         n.st = nxt;
         if (q.st == entry_pkg::S_VEC) begin
            n.widx = q.widx + 2'h1;
            n.pc = q.vw[31:0];
            if (q.rst_entry) begin
               n.ssp = q.vw[63:32];
            end
         end
         if (q.st == entry_pkg::S_PUSH_PCH) begin
            n.ssp = ssp_m6;
         end
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         q <= '{st: entry_pkg::S_IDLE, cnt: 5'h00, ph: 3'h0, level: 3'h0,
                rst_entry: 1'b0, sr_copy: 16'h0000, sr: 16'h0000,
                pc: 32'h00000000, ssp: 32'h00000000, vnum: 8'h00,
                widx: 2'h0, vw: 64'h0, first: 16'h0000,
                addr: 23'h7FFFFF, fc: 3'h0, as_n: 1'b1, ds_n: 1'b1,
                rw: 1'b1, doe: 1'b0, dout: 16'h0000, busy: 1'b0,
                done: 1'b0};
      end else begin
         q <= n;
      end
   end

   assign BUS.address = q.addr;
   assign BUS.function_code_bit2 = q.fc[2];
   assign BUS.function_code_bit1 = q.fc[1];
   assign BUS.function_code_bit0 = q.fc[0];
   assign BUS.address_strobe_n = q.as_n;
   assign BUS.upper_byte_strobe_n = q.ds_n;
   assign BUS.lower_byte_strobe_n = q.ds_n;
   assign BUS.read_write = q.rw;
   assign BUS.cpu_data = q.dout;
   assign BUS.cpu_data_oe = q.doe;
   assign BUSY = q.busy;
   assign DONE = q.done;
   assign STATUS_OUT = q.sr;
   assign SAVED_STATUS = q.sr_copy;
   assign HANDLER_PC = q.pc;
   assign NEW_SSP = q.ssp;
   assign VECTOR_NUM = q.vnum;
   assign FIRST_WORD = q.first;
endmodule
`default_nettype wire

//--- test/interrupt_acknowledge_entry_props.sv
`timescale 1ns/1ps
`default_nettype none
module interrupt_acknowledge_entry_props (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic [23:1] address,
   input wire logic function_code_bit2,
   input wire logic function_code_bit1,
   input wire logic function_code_bit0,
   input wire logic address_strobe_n,
   input wire logic upper_byte_strobe_n,
   input wire logic lower_byte_strobe_n,
   input wire logic transfer_ack_n,
   input wire logic autovector_req_n,
   input wire logic bus_fault_n,
   input wire logic slow_sync_clock
);
   logic [2:0] fc;
   assign fc = {function_code_bit2, function_code_bit1, function_code_bit0};

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SYS_RST);

   sequence s_interrupt_ack_cycle_start;
      $fell(address_strobe_n) && fc == 3'h7;
   endsequence
   sequence s_mem_start;
      $fell(address_strobe_n) && fc != 3'h7;
   endsequence
   sequence s_av_end;
      $rose(address_strobe_n) && !$past(autovector_req_n);
   endsequence

   a_cpu_space_addr: assert property (
      fc == 3'h7 && !address_strobe_n |-> address[23:4] == 20'hFFFFF)
      else $error("cpu space cycle address not all ones");
   a_space_code: assert property (
      !address_strobe_n |-> fc inside {3'h5, 3'h6, 3'h7})
      else $error("bus cycle outside supervisor or cpu space");
   a_strobe_pair: assert property (
      !upper_byte_strobe_n |-> !lower_byte_strobe_n && !address_strobe_n)
      else $error("data strobes not paired inside address strobe");
   a_interrupt_ack_cycle_length: assert property (
      s_interrupt_ack_cycle_start |-> ##[2:17] $rose(address_strobe_n))
      else $error("acknowledge cycle too long");
   a_mem_cycle_len: assert property (
      s_mem_start |-> ##3 $rose(address_strobe_n))
      else $error("plain bus cycle not four clocks");
   a_justify_gap: assert property (
      $rose(address_strobe_n) && $past(fc) == 3'h7 |-> address_strobe_n[*5])
      else $error("bus activity during vector justify");
   a_av_slow_low: assert property (
      s_av_end |-> !$past(slow_sync_clock))
      else $error("autovector cycle ended with slow clock high");
   a_av_release: assert property (
      $rose(address_strobe_n) |-> ##[0:1] autovector_req_n)
      else $error("autovector request held too long");
   a_no_ack_clash: assert property (
      !(!transfer_ack_n && !autovector_req_n))
      else $error("acknowledge and autovector together");
   a_fault_interrupt_ack_cycle: assert property (
      !bus_fault_n |-> fc == 3'h7)
      else $error("bus fault outside acknowledge cycle");
endmodule
`default_nettype wire

//--- test/interrupt_acknowledge_entry_bench.sv
`timescale 1ns/1ps
`default_nettype none
module interrupt_acknowledge_entry_bench;
   logic clk;
   logic sys_rst;
   logic entry_req;
   logic reset_entry;
   logic av_mode;
   logic fault_mode;
   logic mem_we;
   logic busy;
   logic done;
   logic interrupt_ack_cycle_seen;
   logic [2:0] entry_level;
   logic [2:0] interrupt_ack_cycle_level;
   logic [3:0] mem_addr;
   logic [7:0] vector_number;
   logic [7:0] vector_num;
   logic [15:0] status_in;
   logic [15:0] mem_wdata;
   logic [15:0] status_out;
   logic [15:0] saved_status;
   logic [15:0] first_word;
   logic [31:0] pc_in;
   logic [31:0] ssp_in;
   logic [31:0] handler_pc;
   logic [31:0] new_ssp;
   logic [23:1] interrupt_ack_cycle_addr;
   int num_errors = 0;
   int num_checks = 0;
   int interrupt_ack_cycle_count = 0;

   entry_bus_if bus();

   interrupt_entry_unit i_interrupt_entry_unit (
      .CLK(clk), .SYS_RST(sys_rst), .BUS(bus.cpu), .ENTRY_REQ(entry_req),
      .RESET_ENTRY(reset_entry), .ENTRY_LEVEL(entry_level),
      .STATUS_IN(status_in), .PC_IN(pc_in), .SSP_IN(ssp_in), .BUSY(busy),
      .DONE(done), .STATUS_OUT(status_out), .SAVED_STATUS(saved_status),
      .HANDLER_PC(handler_pc), .NEW_SSP(new_ssp), .VECTOR_NUM(vector_num),
      .FIRST_WORD(first_word)
   );

   interrupt_responder #(.SLOW_DIV(5)) i_interrupt_responder (
      .CLK(clk), .SYS_RST(sys_rst), .BUS(bus.periph),
      .AUTOVECTOR_MODE(av_mode), .FAULT_MODE(fault_mode),
      .VECTOR_NUMBER(vector_number), .MEM_WE(mem_we), .MEM_ADDR(mem_addr),
      .MEM_WDATA(mem_wdata), .INTERRUPT_ACK_CYCLE_SEEN(interrupt_ack_cycle_seen), .INTERRUPT_ACK_CYCLE_LEVEL(interrupt_ack_cycle_level)
   );

   interrupt_acknowledge_entry_props i_interrupt_acknowledge_entry_props (
      .CLK(clk), .SYS_RST(sys_rst), .address(bus.address),
      .function_code_bit2(bus.function_code_bit2),
      .function_code_bit1(bus.function_code_bit1),
      .function_code_bit0(bus.function_code_bit0),
      .address_strobe_n(bus.address_strobe_n),
      .upper_byte_strobe_n(bus.upper_byte_strobe_n),
      .lower_byte_strobe_n(bus.lower_byte_strobe_n),
      .transfer_ack_n(bus.transfer_ack_n),
      .autovector_req_n(bus.autovector_req_n),
      .bus_fault_n(bus.bus_fault_n), .slow_sync_clock(bus.slow_sync_clock)
   );

   // Own copy of the wire address, not the responder's view
   always @(posedge clk) begin
      if (!bus.address_strobe_n && bus.function_code_bit2 &&
          bus.function_code_bit1 && bus.function_code_bit0)
         interrupt_ack_cycle_addr <= bus.address;
   end

   // Counts acknowledge cycles the far end has taken
   always @(posedge clk) begin
      if (interrupt_ack_cycle_seen === 1'b1)
         interrupt_ack_cycle_count <= interrupt_ack_cycle_count + 1;
   end

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task conclude;
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task load(input logic [3:0] idx, input logic [15:0] d);
      @(posedge clk);
      mem_we <= 1'b1;
      mem_addr <= idx;
      mem_wdata <= d;
      @(posedge clk);
      mem_we <= 1'b0;
   endtask

   // Waits for the done pulse, then leaves outputs settled
   task run(input logic rst_e, input logic [2:0] lvl);
      int n;
      @(posedge clk);
      entry_req <= 1'b1;
      reset_entry <= rst_e;
      entry_level <= lvl;
      @(posedge clk);
      entry_req <= 1'b0;
      n = 0;
      #1;
      check(busy, 32'h1);
      while (done !== 1'b1 && n < 300) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 300)
         check(32'h0, 32'h1);
      check(busy, 32'h0);
      // Hand back on an edge so callers drive inputs there
      @(posedge clk);
   endtask

   task t_reset;
      load(4'h0, 16'h0000);
      load(4'h1, 16'h2000);
      load(4'h2, 16'h0000);
      load(4'h3, 16'h0210);
      load(4'h8, 16'h4E71);
      run(1'b1, 3'h7);
      check(new_ssp, 32'h0000_2000);
      check(handler_pc, 32'h0000_0210);
      check(first_word, 16'h4E71);
      $display("reset entry test finished");
   endtask

   // Vector 41h sits at byte 104h, words 2 and 3 of the memory
   task t_vectored;
      vector_number <= 8'h41;
      status_in <= 16'h8700;
      run(1'b0, 3'h3);
      check(vector_num, 8'h41);
      check(saved_status, 16'h8700);
      check(status_out, 16'h2300);
      check(new_ssp, 32'h0000_0FFA);
      check(handler_pc, 32'h0000_0210);
      check(first_word, 16'h4E71);
      check(interrupt_ack_cycle_level, 3'h3);
      check(interrupt_ack_cycle_addr, {20'hFFFFF, 3'h3});
      check(interrupt_ack_cycle_count, 32'h1);
      $display("vectored entry test finished");
   endtask

   task t_autovector;
      av_mode <= 1'b1;
      status_in <= 16'h0000;
      for (int l = 1; l < 8; l++) begin
         run(1'b0, l[2:0]);
         check(vector_num, 32'h18 + l);
         check(status_out, 32'h2000 | (l << 8));
         check(interrupt_ack_cycle_addr, {20'hFFFFF, l[2:0]});
      end
      av_mode <= 1'b0;
      check(interrupt_ack_cycle_count, 32'h8);
      $display("autovector test finished");
   endtask

   task t_fault;
      fault_mode <= 1'b1;
      run(1'b0, 3'h5);
      check(vector_num, 8'h18);
      check(interrupt_ack_cycle_count, 32'h9);
      fault_mode <= 1'b0;
      $display("bus fault test finished");
   endtask

   initial begin
      sys_rst = 1'b1;
      entry_req = 1'b0;
      reset_entry = 1'b0;
      entry_level = 3'h1;
      status_in = 16'h0000;
      pc_in = 32'h0001_2344;
      ssp_in = 32'h0000_1000;
      av_mode = 1'b0;
      fault_mode = 1'b0;
      vector_number = 8'h41;
      mem_we = 1'b0;
      mem_addr = 4'h0;
      mem_wdata = 16'h0000;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset;
      t_vectored;
      t_autovector;
      t_fault;
      conclude;
   end

   // Whole run needs well under a thousand clocks
   initial begin
      repeat (4000) @(posedge clk);
      num_errors++;
      conclude;
   end
endmodule
`default_nettype wire
